// ---- src/sacc_params.svh ----
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH

// =====================================================================
// Timing
// =====================================================================
`define SACC_CLK_PERIOD_NS 40
`define SACC_CONV_TIME_NS 1130
`define SACC_CONV_CYCLES (`SACC_CONV_TIME_NS / `SACC_CLK_PERIOD_NS)

// =====================================================================
// Result layout
// =====================================================================
`define SACC_RESULT_W 16
`define SACC_BYTE_W 8
`define SACC_RESULT_RST 16'h0000
`define SACC_LOW_FILL 8'hff
`define SACC_FIFO_DEPTH 4

`endif

// ---- src/sacc_pkg.sv ----
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_ACQUIRE = 2'b00,
    SACC_CONVERT = 2'b01,
    SACC_IDLE = 2'b10
  } sacc_state_t;
endpackage

// ---- src/sacc_fifo.sv ----
`timescale 1ns/1ps
module sacc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [AW-1:0] wr_nxt = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
  wire [AW-1:0] rd_nxt = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;

  assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_nxt;
      if (pop) rd_ptr_ff <= rd_nxt;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem_ff[wr_ptr_ff] <= in_data_i;
  end
endmodule

// ---- src/sacc_ctrl.sv ----
`timescale 1ns/1ps
`include "sacc_params.svh"
module sacc_ctrl #(
  parameter int CONV_CYCLES = `SACC_CONV_CYCLES,
  parameter int RESULT_W = `SACC_RESULT_W,
  parameter int FIFO_DEPTH = `SACC_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic conv_start_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic byte_sel_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [RESULT_W-1:0] sample_data_i,
  output logic busy_o,
  output logic acquire_o,
  output logic hold_o,
  output logic [RESULT_W-1:0] result_bus_o,
  output logic result_bus_oe_o
);
  // ===================================================================
  // Pin synchronisers
  // ===================================================================
  // Three stages; a level is accepted once stages two and three agree.
  logic [2:0] cvs_sync_ff;
  logic [2:0] cs_sync_ff;
  logic [2:0] rd_sync_ff;
  logic [2:0] byte_sync_ff;
  logic cvs_ff;
  logic cs_ff;
  logic rd_ff;
  logic byte_ff;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cvs_sync_ff <= 3'h7;
      cs_sync_ff <= 3'h7;
      rd_sync_ff <= 3'h7;
      byte_sync_ff <= 3'h0;
    end else begin
      cvs_sync_ff <= {cvs_sync_ff[1:0], conv_start_n_i};
      cs_sync_ff <= {cs_sync_ff[1:0], cs_n_i};
      rd_sync_ff <= {rd_sync_ff[1:0], rd_n_i};
      byte_sync_ff <= {byte_sync_ff[1:0], byte_sel_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cvs_ff <= 1'b1;
    end else if (cvs_sync_ff[2] == cvs_sync_ff[1]) begin
      cvs_ff <= cvs_sync_ff[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cs_ff <= 1'b1;
    end else if (cs_sync_ff[2] == cs_sync_ff[1]) begin
      cs_ff <= cs_sync_ff[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_ff <= 1'b1;
    end else if (rd_sync_ff[2] == rd_sync_ff[1]) begin
      rd_ff <= rd_sync_ff[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      byte_ff <= 1'b0;
    end else if (byte_sync_ff[2] == byte_sync_ff[1]) begin
      byte_ff <= byte_sync_ff[2];
    end
  end

  wire nxt_cvs = (cvs_sync_ff[2] == cvs_sync_ff[1]) ? cvs_sync_ff[2] : cvs_ff;
  wire nxt_cs = (cs_sync_ff[2] == cs_sync_ff[1]) ? cs_sync_ff[2] : cs_ff;
  wire start_fall = cvs_ff && !nxt_cvs && !nxt_cs;
  wire cs_fall = cs_ff && !nxt_cs;

  // ===================================================================
  // Conversion sequencer
  // ===================================================================
  localparam int CW = $clog2(CONV_CYCLES + 1);
  sacc_pkg::sacc_state_t state_ff;
  sacc_pkg::sacc_state_t nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [RESULT_W-1:0] latch_ff;
  logic [RESULT_W-1:0] sample_ff;

  wire converting = (state_ff == sacc_pkg::SACC_CONVERT);
  wire abort = converting && (start_fall || cs_fall);
  wire conv_done = converting && (cnt_ff == CW'(1)) && !abort;
  wire conv_go = !converting && start_fall;

  // ===================================================================
  // Sample buffer
  // ===================================================================
  // Words queue here; one is taken only at the hold instant, so a burst
  // from the sampler is not lost while a conversion runs.
  wire smp_valid;
  wire [RESULT_W-1:0] smp_data;

  sacc_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) sacc_fifo_inst (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .in_data_i(sample_data_i),
    .out_valid_o(smp_valid),
    .out_ready_i(conv_go),
    .out_data_o(smp_data)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sacc_pkg::SACC_ACQUIRE: if (start_fall) nxt_state = sacc_pkg::SACC_CONVERT;
      sacc_pkg::SACC_IDLE: begin
        if (start_fall) nxt_state = sacc_pkg::SACC_CONVERT;
        else if (cs_fall) nxt_state = sacc_pkg::SACC_ACQUIRE;
      end
      sacc_pkg::SACC_CONVERT: begin
        if (abort) nxt_state = sacc_pkg::SACC_ACQUIRE;
        else if (conv_done && !nxt_cs) nxt_state = sacc_pkg::SACC_ACQUIRE;
        else if (conv_done) nxt_state = sacc_pkg::SACC_IDLE;
      end
      default: nxt_state = sacc_pkg::SACC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff <= sacc_pkg::SACC_IDLE;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (conv_go) cnt_ff <= CW'(CONV_CYCLES);
      else if (converting && cnt_ff != '0) cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sample_ff <= `SACC_RESULT_RST;
    end else if (conv_go) begin
      sample_ff <= smp_valid ? smp_data : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      latch_ff <= `SACC_RESULT_RST;
    end else begin
      if (abort) latch_ff <= `SACC_RESULT_RST;
      else if (conv_done) latch_ff <= sample_ff;
    end
  end

  // ===================================================================
  // Outputs
  // ===================================================================
  wire [RESULT_W-1:0] folded = {latch_ff[7:0], `SACC_LOW_FILL};
  wire [RESULT_W-1:0] nxt_bus = byte_ff ? folded : latch_ff;
  wire nxt_busy = (nxt_state == sacc_pkg::SACC_CONVERT);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= nxt_busy;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acquire_o <= 1'b0;
    end else begin
      acquire_o <= (nxt_state == sacc_pkg::SACC_ACQUIRE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hold_o <= 1'b0;
    end else begin
      hold_o <= nxt_busy;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_bus_o <= '0;
    end else begin
      result_bus_o <= nxt_bus;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_bus_oe_o <= 1'b0;
    end else begin
      result_bus_oe_o <= !cs_ff && !rd_ff;
    end
  end
endmodule

// ---- test/sacc_ctrl_props.sv ----
`timescale 1ns/1ps
// ==========
// Checker.
module sacc_ctrl_chk #(
  parameter int CONV_CYCLES = 28
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic conv_start_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic byte_sel_i,
  input wire logic sample_ready_o,
  input wire logic busy_o,
  input wire logic acquire_o,
  input wire logic hold_o,
  input wire logic [15:0] result_bus_o,
  input wire logic result_bus_oe_o
);
  logic [7:0] busy_cnt_ff;
  logic [7:0] nxt_busy_cnt;
  assign nxt_busy_cnt = busy_o ? busy_cnt_ff + 8'h01 : 8'h00;
  always_ff @(posedge clk_i) begin
    busy_cnt_ff <= srst_i ? 8'h00 : nxt_busy_cnt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_BUSY_RISE: assert property (
    $fell(conv_start_n_i) && !cs_n_i && !busy_o |-> ##[3:5] busy_o)
    else $error("busy did not rise");
  AST_BUSY_LEN: assert property (
    int'(busy_cnt_ff) <= CONV_CYCLES) else $error("busy too long");
  AST_HOLD: assert property (hold_o == busy_o)
    else $error("hold differs from busy");
  AST_NO_ACQ: assert property (busy_o |-> !acquire_o)
    else $error("acquiring while busy");
  AST_ACQ: assert property (
    $fell(busy_o) && !cs_n_i |-> ##[0:1] acquire_o)
    else $error("no acquisition after busy");
  AST_OE_ON: assert property (
    (!cs_n_i && !rd_n_i)[*6] |-> result_bus_oe_o) else $error("bus off");
  AST_OE_OFF: assert property (
    (cs_n_i || rd_n_i)[*6] |-> !result_bus_oe_o) else $error("bus on");
  AST_FOLD: assert property (
    byte_sel_i[*6] ##0 result_bus_oe_o |-> result_bus_o[7:0] == 8'hff)
    else $error("low byte not filled");
  AST_READY: assert property (
    !sample_ready_o && !busy_o |=> !sample_ready_o || busy_o)
    else $error("sample taken outside hold");
endmodule
bind sacc_ctrl sacc_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES)) sacc_ctrl_chk_inst (
  .clk_i(clk_i), .srst_i(srst_i), .conv_start_n_i(conv_start_n_i),
  .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .byte_sel_i(byte_sel_i),
  .sample_ready_o(sample_ready_o), .busy_o(busy_o), .acquire_o(acquire_o),
  .hold_o(hold_o), .result_bus_o(result_bus_o),
  .result_bus_oe_o(result_bus_oe_o));

// ---- test/sacc_host.sv ----
`timescale 1ns/1ps
// ==========
// Host strobe model.
module sacc_host (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic go_i,
  output logic conv_start_n_o,
  output logic cs_n_o
);
  logic [1:0] cnt_ff;
  logic cs_n_ff;
  // Three cycles low is above the minimum and well inside the quiet span.
  assign conv_start_n_o = (cnt_ff == 2'h0);
  assign cs_n_o = cs_n_ff;
  always_ff @(posedge clk_i) begin
    cs_n_ff <= srst_i;
    cnt_ff <= srst_i ? 2'h0 : go_i ? 2'h3 : cnt_ff - {1'b0, |cnt_ff};
  end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
// ==========
// Testbench.
module tb;
  logic clk = 1'b0, srst = 1'b1, go = 1'b0, rd_n = 1'b1, byte_sel = 1'b0;
  logic in_valid = 1'b0, in_ready, start_n, cs_n;
  logic busy, oe, oe_q = 1'b0;
  logic [15:0] in_data = 16'h0000, bus;
  logic [15:0] exp_q[$];
  int seed = 32'h83bc;
  int mismatches = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  sacc_host sacc_host_inst (.clk_i(clk), .srst_i(srst), .go_i(go),
    .conv_start_n_o(start_n), .cs_n_o(cs_n));
  sacc_ctrl #(.CONV_CYCLES(12)) sacc_ctrl_inst (.clk_i(clk), .srst_i(srst),
    .conv_start_n_i(start_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .byte_sel_i(byte_sel), .sample_valid_i(in_valid),
    .sample_ready_o(in_ready),
    .sample_data_i(in_data), .busy_o(busy), .acquire_o(), .hold_o(),
    .result_bus_o(bus), .result_bus_oe_o(oe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rd_word(input logic bsel, input logic [15:0] w);
    byte_sel = bsel;
    exp_q.push_back(bsel ? {w[7:0], 8'hff} : w);
    repeat (3) @(negedge clk);
    rd_n = 1'b0;
    repeat (8) @(negedge clk);
    rd_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic go_wait(input logic lvl);
    int n;
    for (n = 0; n < 40 && busy !== lvl; n++) @(negedge clk);
    check({15'h0, busy}, {15'h0, lvl});
  endtask
  task automatic pulse;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
  endtask
  // Rising edge of the enable marks a fresh read; data is registered with it.
  always @(posedge clk) begin
    oe_q <= oe;
    if (oe === 1'b1 && oe_q !== 1'b1) check(bus, exp_q.pop_front());
  end
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    int i;
    logic [15:0] s[4];
    repeat (12) @(negedge clk);
    srst = 1'b0;
    in_valid = 1'b1;
    for (i = 0; i < 4; i++) begin
      s[i] = i == 0 ? 16'hffff : i == 1 ? 16'h0000 : 16'($random(seed));
      in_data = s[i];
      @(posedge clk);
      while (in_ready !== 1'b1) @(posedge clk);
      @(negedge clk);
    end
    @(negedge clk);
    check({15'h0, in_ready}, 16'h0000);
    in_valid = 1'b0;
    for (i = 0; i < 4; i++) begin
      pulse;
      go_wait(1'b1);
      go_wait(1'b0);
      repeat (2) @(negedge clk);
      rd_word(1'b0, s[i]);
      rd_word(1'b1, s[i]);
    end
    // A second strobe in mid-conversion must abort and clear the result latch.
    // A nonzero sample is queued so that only the abort can give zero.
    in_data = 16'h8000;
    in_valid = 1'b1;
    @(negedge clk);
    in_valid = 1'b0;
    pulse;
    go_wait(1'b1);
    pulse;
    repeat (6) @(negedge clk);
    check({15'h0, busy}, 16'h0000);
    repeat (24) @(negedge clk);
    rd_word(1'b0, 16'h0000);
    print_verdict;
  end
endmodule
